// ---- rtl/counter_array_timebase_irq.sv ----
// Counter array: 16-bit counter, timebase, channel flags and interrupt tree on AXI4-Lite
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "counter_array_consts.svh"

// Behaviour
// R01: One 16-bit counter read as two bytes
// R02: Low-byte read latches high byte snapshot
// R03: Counter reads never disturb counting
// R04: Timebase select picks clock divisions or timer0
// R05: Code 3 counts external input falling edges
// R06: Codes 5,6 count synced oscillators divided by 8
// R07: Wrap from maximum sets overflow flag
// R08: Overflow flag interrupts only when enabled
// R09: Overflow flag stays until software clears it
// R10: Idle suspend clear keeps counting in idle
// R11: Idle suspend set stops counting in idle
// R12: Intermediate overflow from selectable bit 8..11
// R13: Each channel owns its event flag
// R14: Flags set regardless of interrupt enables
// R15: Interrupt is OR of enabled set flags
// R16: Processor gates with global and array enables
// R17: Three 16-bit compare channels with I/O lines
// R18: Watchdog mode at reset locks mode writes
module counter_array_timebase_irq
#(
   parameter int CHANNELS = 3
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic cpu_idle,
   input wire logic timer0_overflow,
   input wire logic external_count_input,
   input wire logic ext_osc_clk,
   input wire logic lfo_clk,
   output logic [CHANNELS-1:0] channel_io_line_out,
   output logic [CHANNELS-1:0] channel_io_line_oe,
   output logic irq
);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == `CA_OFF_COUNT_LOW) || (a == `CA_OFF_COUNT_HIGH) ||
                   (a == `CA_OFF_MODE) || (a == `CA_OFF_STATUS) ||
                   (a == `CA_OFF_MASK) || (a == `CA_OFF_CMP0) ||
                   (a == `CA_OFF_CMP1) || (a == `CA_OFF_CMP2);
   endfunction

   function automatic logic [31:0] lane_mask(input logic [3:0] s);
      lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   // ****************************************
   // Register bus
   // ****************************************
   logic aw_hold_r;
   logic w_hold_r;
   logic [7:0] waddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   logic do_write;
   logic do_read;
   logic [31:0] wmask;
   logic [31:0] wbits;

   assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
   assign s_axi_wready = ~w_hold_r & ~bvalid_r;
   assign do_write = ce & aw_hold_r & w_hold_r & ~bvalid_r;
   assign s_axi_arready = ~rvalid_r;
   assign do_read = ce & s_axi_arvalid & ~rvalid_r;
   assign wmask = lane_mask(wstrb_r);
   assign wbits = wdata_r & wmask;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_r <= 1'b0;
         waddr_r <= 8'h00;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_r <= 1'b1;
            waddr_r <= s_axi_awaddr;
         end
         else if (do_write)
            aw_hold_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_hold_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end
      else if (ce)
      begin
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         else if (do_write)
            w_hold_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= `CA_RESP_OKAY;
      end
      else if (ce)
      begin
         if (do_write)
         begin
            bvalid_r <= 1'b1;
            bresp_r <= addr_known(waddr_r) ? `CA_RESP_OKAY : `CA_RESP_SLVERR;
         end
         else if (s_axi_bready)
            bvalid_r <= 1'b0;
      end
   end

   // ****************************************
   // Mode, mask and write decode
   // ****************************************
   logic [15:0] mode_r;
   logic [4:0] mask_r;
   logic [4:0] status_r;
   logic [15:0] count_r;
   logic [7:0] snap_r;
   logic [15:0] mode_wmask;
   logic wr_low;
   logic wr_high;
   logic cnt_wr;
   counter_array_pkg::timebase_type tb_sel;
   logic [1:0] iov_sel;
   logic wdog;

   assign tb_sel = counter_array_pkg::timebase_type'(mode_r[`CA_MODE_TB_MSB:`CA_MODE_TB_LSB]);
   assign iov_sel = mode_r[`CA_MODE_IOV_MSB:`CA_MODE_IOV_LSB];
   assign wdog = mode_r[`CA_MODE_WDOG];
   assign wr_low = do_write && (waddr_r == `CA_OFF_COUNT_LOW) && wstrb_r[0];
   assign wr_high = do_write && (waddr_r == `CA_OFF_COUNT_HIGH) && wstrb_r[0];
   assign cnt_wr = wr_low | wr_high;
   // Watchdog mode lets only its own bit be changed
   assign mode_wmask = (wdog ? (16'h0001 << `CA_MODE_WDOG) : `CA_MODE_VALID) & wmask[15:0]; // R18

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mode_r <= `CA_MODE_RESET; // R18
      else if (ce && do_write && (waddr_r == `CA_OFF_MODE))
         mode_r <= (mode_r & ~mode_wmask) | (wdata_r[15:0] & mode_wmask); // R18
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mask_r <= 5'h00;
      else if (ce && do_write && (waddr_r == `CA_OFF_MASK))
         mask_r <= (mask_r & ~wmask[4:0]) | (wbits[4:0] & `CA_ST_VALID);
   end

   // ****************************************
   // Timebase
   // ****************************************
   logic [3:0] pre_r;
   logic tick12;
   logic tick4;
   logic [2:0] pin_vec;
   logic [2:0] pin_fall;
   logic [2:0] ext_div_r;
   logic [2:0] lfo_div_r;
   logic ext_tick;
   logic lfo_tick;
   logic tick;
   logic run;
   logic count_tick;

   assign pin_vec = {lfo_clk, ext_osc_clk, external_count_input};

   genvar gp;
   generate
      for (gp = 0; gp < 3; gp++)
      begin : g_pin
         pin_sync u_sync
         (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .pin_in(pin_vec[gp]),
            .level(),
            .fall(pin_fall[gp])
         );
      end
   endgenerate

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pre_r <= 4'h0;
      else if (ce)
         pre_r <= (pre_r == `CA_PRE12_LAST) ? 4'h0 : pre_r + 4'h1;
   end

   assign tick12 = ce & (pre_r == `CA_PRE12_LAST); // R04
   // Twelve is a multiple of four, so one prescaler serves both
   assign tick4 = ce & ((pre_r & `CA_PRE4_MASK) == `CA_PRE4_MASK); // R04

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ext_div_r <= 3'h0;
         lfo_div_r <= 3'h0;
      end
      else if (ce)
      begin
         if (pin_fall[1])
            ext_div_r <= ext_div_r + 3'h1; // R06
         if (pin_fall[2])
            lfo_div_r <= lfo_div_r + 3'h1; // R06
      end
   end

   assign ext_tick = pin_fall[1] & (ext_div_r == `CA_DIV8_LAST); // R06
   assign lfo_tick = pin_fall[2] & (lfo_div_r == `CA_DIV8_LAST); // R06

   always_comb
   begin
      case (tb_sel) // R04
         counter_array_pkg::tb_div12: tick = tick12;
         counter_array_pkg::tb_div4: tick = tick4;
         counter_array_pkg::tb_timer0: tick = ce & timer0_overflow;
         counter_array_pkg::tb_ext_fall: tick = pin_fall[0]; // R05
         counter_array_pkg::tb_sysclk: tick = ce;
         counter_array_pkg::tb_extosc8: tick = ext_tick; // R06
         counter_array_pkg::tb_lfo8: tick = lfo_tick; // R06
         default: tick = 1'b0;
      endcase
   end

   assign run = ~(mode_r[`CA_MODE_IDLE] & cpu_idle); // R10 R11
   assign count_tick = tick & run;

   // ****************************************
   // Counter and snapshot
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         count_r <= 16'h0000;
      else if (ce)
      begin
         if (wr_low)
            count_r[7:0] <= wdata_r[7:0];
         else if (wr_high)
            count_r[15:8] <= wdata_r[7:0];
         else if (count_tick)
            count_r <= count_r + 16'h0001; // R01 R03
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         snap_r <= 8'h00;
      else if (do_read && (s_axi_araddr == `CA_OFF_COUNT_LOW))
         snap_r <= count_r[15:8]; // R02
   end

   // ****************************************
   // Channels
   // ****************************************
   logic [15:0] cmp_r [CHANNELS];
   logic [CHANNELS-1:0] ch_match;
   logic [CHANNELS-1:0] io_r;

   genvar gc;
   generate
      for (gc = 0; gc < CHANNELS; gc++)
      begin : g_ch
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               cmp_r[gc] <= 16'hffff;
            else if (ce && do_write && (waddr_r == `CA_OFF_CMP0 + 8'(4 * gc)))
               cmp_r[gc] <= (cmp_r[gc] & ~wmask[15:0]) | wbits[15:0]; // R17
         end

         assign ch_match[gc] = count_tick & ~cnt_wr & (count_r == cmp_r[gc]); // R13

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               io_r[gc] <= 1'b0;
            else if (ce && ch_match[gc])
               io_r[gc] <= ~io_r[gc]; // R17
         end
      end
   endgenerate

   assign channel_io_line_out = io_r;
   assign channel_io_line_oe = mode_r[`CA_MODE_IOEN_MSB:`CA_MODE_IOEN_LSB]; // R17

   // ****************************************
   // Flags and interrupt
   // ****************************************
   logic ovf_set;
   logic iov_set;
   logic [15:0] iov_mask;
   logic [4:0] flag_set;
   logic [4:0] flag_clr;

   assign ovf_set = count_tick & ~cnt_wr & (count_r == `CA_COUNT_MAX); // R07
   assign iov_mask = 16'((17'h00001 << (`CA_IOV_BASE + iov_sel)) - 17'h00001);
   assign iov_set = count_tick & ~cnt_wr & ((count_r & iov_mask) == iov_mask); // R12
   assign flag_set = {ch_match, iov_set, ovf_set}; // R14
   assign flag_clr = (do_write && (waddr_r == `CA_OFF_STATUS)) ? wbits[4:0] : 5'h00;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         status_r <= 5'h00;
      else if (ce)
         status_r <= (status_r & ~flag_clr) | flag_set; // R09 R13 R14
   end

   assign irq = |(status_r & mask_r); // R08 R15

   // ****************************************
   // Read data
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rresp_r <= `CA_RESP_OKAY;
         rdata_r <= 32'h0000_0000;
      end
      else if (ce)
      begin
         if (do_read)
         begin
            rvalid_r <= 1'b1;
            rresp_r <= addr_known(s_axi_araddr) ? `CA_RESP_OKAY : `CA_RESP_SLVERR;
            case (s_axi_araddr)
               `CA_OFF_COUNT_LOW: rdata_r <= {24'h000000, count_r[7:0]}; // R01
               `CA_OFF_COUNT_HIGH: rdata_r <= {24'h000000, snap_r}; // R02
               `CA_OFF_MODE: rdata_r <= {16'h0000, mode_r};
               `CA_OFF_STATUS: rdata_r <= {27'h0000000, status_r};
               `CA_OFF_MASK: rdata_r <= {27'h0000000, mask_r};
               `CA_OFF_CMP0: rdata_r <= {16'h0000, cmp_r[0]};
               `CA_OFF_CMP1: rdata_r <= {16'h0000, cmp_r[1]};
               `CA_OFF_CMP2: rdata_r <= {16'h0000, cmp_r[2]};
               default: rdata_r <= 32'h0000_0000;
            endcase
         end
         else if (s_axi_rready)
            rvalid_r <= 1'b0;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence wrap_seq;
      count_tick && !cnt_wr && (count_r == `CA_COUNT_MAX);
   endsequence

   sequence low_read_seq;
      do_read && (s_axi_araddr == `CA_OFF_COUNT_LOW);
   endsequence

   chk_count_step: assert property (count_tick && !cnt_wr |=> count_r == $past(count_r) + 16'h0001) // R01
      else $error("counter did not step on tick");
   chk_snapshot_latch: assert property (low_read_seq |=> snap_r == $past(count_r[15:8])) // R02
      else $error("snapshot did not latch high byte");
   chk_read_no_disturb: assert property (low_read_seq ##0 (count_tick && !cnt_wr)
      |=> count_r == $past(count_r) + 16'h0001) // R03
      else $error("counter read disturbed counting");
   chk_div12_gap: assert property ((tb_sel == counter_array_pkg::tb_div12) && tick && run
      ##1 ce[*8] |-> !tick) // R04
      else $error("divide by twelve ticked early");
   chk_ext_fall_count: assert property ((tb_sel == counter_array_pkg::tb_ext_fall) && pin_fall[0]
      && run && !cnt_wr |=> count_r == $past(count_r) + 16'h0001) // R05
      else $error("external falling edge not counted");
   chk_osc_div8: assert property ((tb_sel == counter_array_pkg::tb_extosc8) && pin_fall[1]
      && (ext_div_r != `CA_DIV8_LAST) && !cnt_wr |=> $stable(count_r)) // R06
      else $error("oscillator divider counted early");
   chk_ovf_wrap: assert property (wrap_seq |=> status_r[`CA_ST_OVF] && (count_r == 16'h0000)) // R07
      else $error("wrap did not set overflow flag");
   chk_irq_masked: assert property (!mask_r[`CA_ST_OVF] && (status_r == 5'h01) |-> !irq) // R08
      else $error("masked overflow raised interrupt");
   chk_flag_sticky: assert property (status_r[`CA_ST_OVF] && !flag_clr[`CA_ST_OVF] && ce
      |=> status_r[`CA_ST_OVF]) // R09
      else $error("overflow flag cleared by itself");
   chk_idle_runs: assert property (!mode_r[`CA_MODE_IDLE] && cpu_idle && ce && !cnt_wr
      && (tb_sel == counter_array_pkg::tb_sysclk) |=> count_r == $past(count_r) + 16'h0001) // R10
      else $error("counter stopped in idle without suspend");
   chk_idle_hold: assert property (mode_r[`CA_MODE_IDLE] && cpu_idle && !cnt_wr
      |=> $stable(count_r)) // R11
      else $error("counter ran during suspended idle");
   chk_iov_set: assert property (count_tick && !cnt_wr && (count_r[7:0] == 8'hff)
      && (iov_sel == 2'b00) |=> status_r[`CA_ST_IOV]) // R12
      else $error("intermediate overflow flag missed");
   chk_channel_flag: assert property (ch_match[0] && !mask_r[`CA_ST_CH_LSB]
      |=> status_r[`CA_ST_CH_LSB] && !irq[*1]) // R13 R14
      else $error("channel flag not set while disabled");
   chk_irq_enabled: assert property ((status_r & mask_r) != 5'h00
      |-> irq ##1 (irq || $changed(status_r) || $changed(mask_r))) // R15
      else $error("enabled flag did not raise interrupt");
   chk_wdog_lock: assert property (wdog && do_write && (waddr_r == `CA_OFF_MODE)
      |=> $stable(mode_r[`CA_MODE_TB_MSB:`CA_MODE_TB_LSB])) // R18
      else $error("mode changed under watchdog");
endmodule
`default_nettype wire

// ---- rtl/counter_array_consts.svh ----
// Register offsets, field positions, reset values and divider counts of the counter array
`ifndef COUNTER_ARRAY_CONSTS_SVH
`define COUNTER_ARRAY_CONSTS_SVH

`define CA_OFF_COUNT_LOW 8'h00
`define CA_OFF_COUNT_HIGH 8'h04
`define CA_OFF_MODE 8'h08
`define CA_OFF_STATUS 8'h0c
`define CA_OFF_MASK 8'h10
`define CA_OFF_CMP0 8'h14
`define CA_OFF_CMP1 8'h18
`define CA_OFF_CMP2 8'h1c

`define CA_MODE_OVF_IE 0
`define CA_MODE_TB_LSB 1
`define CA_MODE_TB_MSB 3
`define CA_MODE_IOV_LSB 4
`define CA_MODE_IOV_MSB 5
`define CA_MODE_WDOG 6
`define CA_MODE_IDLE 7
`define CA_MODE_IOEN_LSB 8
`define CA_MODE_IOEN_MSB 10
`define CA_MODE_VALID 16'h07ff
`define CA_MODE_RESET 16'h0040

`define CA_ST_OVF 0
`define CA_ST_IOV 1
`define CA_ST_CH_LSB 2
`define CA_ST_VALID 5'h1f

`define CA_PRE12_LAST 4'hb
`define CA_PRE4_MASK 4'h3
`define CA_DIV8_LAST 3'h7
`define CA_IOV_BASE 8
`define CA_COUNT_MAX 16'hffff

`define CA_RESP_OKAY 2'b00
`define CA_RESP_SLVERR 2'b10

`endif

// ---- rtl/counter_array_pkg.sv ----
// Types shared by the counter array design files
package counter_array_pkg;
   typedef enum logic [2:0]
   {
      tb_div12 = 3'h0,
      tb_div4 = 3'h1,
      tb_timer0 = 3'h2,
      tb_ext_fall = 3'h3,
      tb_sysclk = 3'h4,
      tb_extosc8 = 3'h5,
      tb_lfo8 = 3'h6,
      tb_reserved = 3'h7
   } timebase_type;
endpackage

// ---- rtl/pin_sync.sv ----
// Three-stage pin synchroniser with agreed level and falling-edge pulse
`timescale 1ns/1ps
`default_nettype none
module pin_sync
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic pin_in,
   output logic level,
   output logic fall
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic level_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
      end
      else if (ce)
      begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Level only moves once two later stages agree
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         level_r <= 1'b1;
      else if (ce && (s2_r == s3_r))
         level_r <= s2_r;
   end

   assign level = level_r;
   assign fall = ce & level_r & ~s2_r & ~s3_r;
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the counter array over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
`include "counter_array_consts.svh"
`define CHECK(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         n_mismatch++; \
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); \
      end \
   end

module testbench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic cpu_idle = 1'b1;
   logic timer0_overflow = 1'b0;
   // Processor-side gates that sit outside the block
   logic global_irq_enable = 1'b1;
   logic array_irq_enable = 1'b0;
   logic pin_wave = 1'b1;
   logic [4:0] phase = 5'h0;
   logic [2:0] channel_io_line_out, channel_io_line_oe;
   int n_mismatch = 0;
   int comparisons = 0;
   logic [31:0] d;
   logic [15:0] c, c2;
   int lo_lim[8] = '{18, 58, 18, 28, 238, 2, 2, 0};
   int hi_lim[8] = '{22, 62, 22, 32, 242, 5, 5, 0};

   counter_array_timebase_irq #(.CHANNELS(3)) uut
   (
      .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cpu_idle(cpu_idle),
      .timer0_overflow(timer0_overflow), .external_count_input(pin_wave),
      .ext_osc_clk(pin_wave), .lfo_clk(pin_wave), .channel_io_line_out(channel_io_line_out),
      .channel_io_line_oe(channel_io_line_oe), .irq(irq)
   );

   always #2.5 aclk = ~aclk;

   // ********************************
   // Background count sources
   // ********************************
   // Pins fall every 8 cycles, well inside the quarter-rate limit; timer0 pulses every 12
   always @(posedge aclk)
   begin
      phase <= (phase == 5'h17) ? 5'h00 : phase + 5'h01;
      pin_wave <= phase[2];
      timer0_overflow <= (phase == 5'h00) || (phase == 5'h0c);
   end

   // ********************************
   // Bus tasks
   // ********************************
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      int n;
      logic aw_p;
      logic w_p;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw_p = 1'b1;
      w_p = 1'b1;
      n = 0;
      // Sampled in the active region, so these are the values before the edge
      while ((aw_p || w_p) && n < 100)
      begin
         @(posedge aclk);
         if (aw_p && s_axi_awready)
         begin
            s_axi_awvalid <= 1'b0;
            aw_p = 1'b0;
         end
         if (w_p && s_axi_wready)
         begin
            s_axi_wvalid <= 1'b0;
            w_p = 1'b0;
         end
         n++;
      end
      while (!s_axi_bvalid && n < 200)
      begin
         @(posedge aclk);
         n++;
      end
      s_axi_bready <= 1'b0;
      if (n >= 200)
         n_mismatch++;
      `CHECK(s_axi_bresp, er)
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (!s_axi_arready && n < 100);
      s_axi_arvalid <= 1'b0;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (!s_axi_rvalid && n < 200);
      s_axi_rready <= 1'b0;
      if (n >= 200)
         n_mismatch++;
      v = s_axi_rdata;
      `CHECK(s_axi_rresp, er)
   endtask

   task automatic rd_count(output logic [15:0] v);
      logic [31:0] lo;
      logic [31:0] hi;
      rd(`CA_OFF_COUNT_LOW, lo, `CA_RESP_OKAY);
      rd(`CA_OFF_COUNT_HIGH, hi, `CA_RESP_OKAY);
      v = {hi[7:0], lo[7:0]};
   endtask

   task automatic set_count(input logic [15:0] v);
      wr(`CA_OFF_COUNT_HIGH, {24'h0, v[15:8]}, `CA_RESP_OKAY);
      wr(`CA_OFF_COUNT_LOW, {24'h0, v[7:0]}, `CA_RESP_OKAY);
   endtask

   // Counting window: idle suspend is kept set, so leaving idle opens the gate
   task automatic run(input int n);
      @(posedge aclk);
      cpu_idle <= 1'b0;
      repeat (n) @(posedge aclk);
      cpu_idle <= 1'b1;
   endtask

   task give_verdict;
      if (n_mismatch == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (40000) @(posedge aclk);
      n_mismatch++;
      give_verdict();
   end

   // ********************************
   // Test sequence
   // ********************************
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`CA_OFF_MODE, d, `CA_RESP_OKAY);
      `CHECK(d, 32'h0000_0040)
      rd(`CA_OFF_STATUS, d, `CA_RESP_OKAY);
      `CHECK(d, 32'h0)
      rd(`CA_OFF_MASK, d, `CA_RESP_OKAY);
      `CHECK(d, 32'h0)
      for (int k = 0; k < 3; k++)
      begin
         rd(8'(`CA_OFF_CMP0 + 4 * k), d, `CA_RESP_OKAY);
         `CHECK(d, 32'h0000_ffff)
      end
      `CHECK({irq, channel_io_line_oe, channel_io_line_out}, 7'h00)
      rd(8'h20, d, `CA_RESP_SLVERR);
      `CHECK(d, 32'h0)
      wr(8'h20, 32'hffff_ffff, `CA_RESP_SLVERR);
      // Watchdog lock: only the watchdog bit follows a mode write
      wr(`CA_OFF_MODE, 32'h0000_07ff, `CA_RESP_OKAY);
      rd(`CA_OFF_MODE, d, `CA_RESP_OKAY);
      `CHECK(d, 32'h0000_0040)
      wr(`CA_OFF_MODE, 32'h0, `CA_RESP_OKAY);
      wr(`CA_OFF_MODE, 32'hffff_ffff, `CA_RESP_OKAY);
      rd(`CA_OFF_MODE, d, `CA_RESP_OKAY);
      `CHECK(d, 32'h0000_07ff)
      wr(`CA_OFF_MODE, 32'h0, `CA_RESP_OKAY);
      rd(`CA_OFF_MODE, d, `CA_RESP_OKAY);
      `CHECK(d, 32'h0000_07bf)
      `CHECK(channel_io_line_oe, 3'b111)
      wr(`CA_OFF_MODE, 32'h0, `CA_RESP_OKAY);
      // Every timebase code over a 240-cycle window; pins at 30 falls, timer0 at 20
      for (int k = 0; k < 8; k++)
      begin
         wr(`CA_OFF_MODE, 32'h80 | (k << 1), `CA_RESP_OKAY);
         set_count(16'h0000);
         run(240);
         rd_count(c);
         `CHECK(c >= lo_lim[k] && c <= hi_lim[k], 1'b1)
         rd_count(c2);
         `CHECK(c2, c)
      end
      // Idle suspend clear: idle does not stop the count
      wr(`CA_OFF_MODE, 32'h08, `CA_RESP_OKAY);
      rd_count(c);
      repeat (50) @(posedge aclk);
      rd_count(c2);
      `CHECK((c2 - c) > 16'h0028, 1'b1)
      // Snapshot: high byte comes from the latch even after the count moved on
      wr(`CA_OFF_MODE, 32'h88, `CA_RESP_OKAY);
      set_count(16'h12ff);
      rd(`CA_OFF_COUNT_LOW, d, `CA_RESP_OKAY);
      `CHECK(d[7:0], 8'hff)
      run(20);
      rd(`CA_OFF_COUNT_HIGH, d, `CA_RESP_OKAY);
      `CHECK(d[7:0], 8'h12)
      rd_count(c);
      `CHECK(c >= 16'h1310 && c <= 16'h1318, 1'b1)
      // Intermediate overflow position; a start at 0x00fa only crosses bit 8
      for (int s = 0; s < 4; s++)
      begin
         wr(`CA_OFF_MODE, 32'h88 | (s << 4), `CA_RESP_OKAY);
         for (int j = 0; j < 2; j++)
         begin
            wr(`CA_OFF_STATUS, 32'h1f, `CA_RESP_OKAY);
            set_count(j == 0 ? 16'((1 << (8 + s)) - 6) : 16'h00fa);
            run(20);
            rd(`CA_OFF_STATUS, d, `CA_RESP_OKAY);
            `CHECK(d[1:0], {(j == 0 || s == 0), 1'b0})
         end
      end
      // Channel events, pin toggles and the interrupt tree
      wr(`CA_OFF_MODE, 32'h788, `CA_RESP_OKAY);
      for (int k = 0; k < 3; k++)
         wr(8'(`CA_OFF_CMP0 + 4 * k), 32'h10 * (k + 1), `CA_RESP_OKAY);
      wr(`CA_OFF_STATUS, 32'h1f, `CA_RESP_OKAY);
      set_count(16'h0000);
      run(64);
      rd(`CA_OFF_STATUS, d, `CA_RESP_OKAY);
      `CHECK(d, 32'h1c)
      `CHECK({irq, channel_io_line_oe, channel_io_line_out}, 7'h3f)
      for (int k = 2; k < 5; k++)
      begin
         wr(`CA_OFF_MASK, 32'h1 << k, `CA_RESP_OKAY);
         `CHECK(irq, 1'b1)
      end
      wr(`CA_OFF_STATUS, 32'h04, `CA_RESP_OKAY);
      rd(`CA_OFF_STATUS, d, `CA_RESP_OKAY);
      `CHECK(d, 32'h18)
      wr(`CA_OFF_MASK, 32'h04, `CA_RESP_OKAY);
      `CHECK(irq, 1'b0)
      // Wrap from 0xffff; mode bit 0 alone must not raise the request
      wr(`CA_OFF_STATUS, 32'h1f, `CA_RESP_OKAY);
      wr(`CA_OFF_MODE, 32'h789, `CA_RESP_OKAY);
      set_count(16'hfff0);
      run(20);
      rd(`CA_OFF_STATUS, d, `CA_RESP_OKAY);
      `CHECK(d, 32'h03)
      `CHECK(irq, 1'b0)
      wr(`CA_OFF_MASK, 32'h01, `CA_RESP_OKAY);
      `CHECK(irq, 1'b1)
      `CHECK(irq & global_irq_enable & array_irq_enable, 1'b0)
      array_irq_enable <= 1'b1;
      @(posedge aclk);
      `CHECK(irq & global_irq_enable & array_irq_enable, 1'b1)
      repeat (30) @(posedge aclk);
      rd(`CA_OFF_STATUS, d, `CA_RESP_OKAY);
      `CHECK(d[0], 1'b1)
      wr(`CA_OFF_STATUS, 32'h01, `CA_RESP_OKAY);
      rd(`CA_OFF_STATUS, d, `CA_RESP_OKAY);
      `CHECK({irq, d[1:0]}, 3'b010)
      give_verdict();
   end
endmodule
`default_nettype wire
